// ===== clk_synth.sv
// Digital control of a clock synthesis loop: pre-scale, feedback and five
// post-scale counters, detector gate, loop reset, lock flag and reference
// switchover. Reference clocks are slow against pclk and sampled as levels;
// the oscillator is a tick enable whose period in pclk cycles the loop trims.
`timescale 1ns/10ps

// Overview of operation
// [R1] Pre-scale and feedback counters accept every setting from 1 to 512.
// [R2] Pre-scale counter only divides; it has no high or low counts.
// [R3] Five independent post-scale counters each divide the oscillator for one output.
// [R4] Post counters reach 512 at 50% duty, only 256 at other duties.
// [R5] Post divide ratio equals high count plus low count in oscillator cycles.
// [R6] Output rate is reference times feedback over pre-scale and post-scale.
// [R7] A chained counter pair divides by the product of both settings.
// [R8] Chaining comes from build configuration and cannot change at run time.
// [R9] Duty steps are 100% over divide value, via high and low counts in whole cycles.
// [R10] Detector gate low freezes oscillator control; outputs keep running.
// [R11] Loop reset clears counters, outputs, lock and restores nominal oscillator.
// [R12] On reset release counters resynchronise to the selected reference.
// [R13] User logic pulses loop reset after lock loss or switchover.
// [R14] User logic asserts loop reset only after the reference is stable.
// [R15] Lock rises when feedback matches reference; it may toggle meanwhile.
// [R16] Automatic mode moves to the backup when the current reference stops.
// [R17] Loss flag per reference plus selected-reference indicator are exported.
// [R18] Automatic switching may go back and forth without limit.
// [R19] User logic switches manually when references differ beyond 20%.
// [R20] Primary low for about two periods raises its loss flag and switches.
// [R21] Multiplexer changes only on a falling edge of an available reference.
// [R22] Indicator is low for primary, high for backup reference.
// [R23] Manual request acts on its rising edge only, never on falling.
// [R24] Switch gates old clock on its falling edge, then moves on new fall.
// [R25] Switch waits until the target reference is present.
// [R26] Loss is found by counting the other reference's edges; toggling clears it.
module clk_synth #(
    parameter logic [clk_synth_pkg::PER_W-1:0]    NOMINAL_PERIOD = 16'h0004,
    parameter logic [clk_synth_pkg::PER_W-1:0]    MAX_PERIOD     = 16'h0100,
    parameter logic [clk_synth_pkg::LOCK_W-1:0]   LOCK_COUNT     = 4'h4,
    parameter logic [clk_synth_pkg::LOSS_W-1:0]   LOSS_EDGES     = 3'h2,
    parameter logic [clk_synth_pkg::NUM_POST-1:0] CASCADE_MASK   = 5'h00
) (
    input  wire logic                                    pclk,
    input  wire logic                                    presetn,
    input  wire logic                                    psel,
    input  wire logic                                    penable,
    input  wire logic                                    pwrite,
    input  wire logic [7:0]                              paddr,
    input  wire logic [31:0]                             pwdata,
    output logic      [31:0]                             prdata,
    output logic                                         pready,
    output logic                                         pslverr,
    input  wire logic                                    primary_ref_clock,
    input  wire logic                                    backup_ref_clock,
    output logic                                         selected_ref_clock,
    output logic      [clk_synth_pkg::NUM_POST-1:0]      output_clocks,
    output clk_synth_pkg::status_t                       status
);
    import clk_synth_pkg::*;

    typedef struct packed {
        ctrl_t                          ctrl;
        logic [CNT_W-1:0]               pre_m1;
        logic [CNT_W-1:0]               fb_m1;
        post_cfg_t [NUM_POST-1:0]       post;
        logic                           p_prev;
        logic                           b_prev;
        logic [LOSS_W-1:0]              loss_cnt0;
        logic [LOSS_W-1:0]              loss_cnt1;
        logic                           loss0;
        logic                           loss1;
        sw_state_t                      sw_state;
        logic                           sel;
        logic                           gated;
        logic                           req_prev;
        logic                           ref_out;
        logic                           sync_wait;
        logic [PER_W-1:0]               ctl;
        logic [PER_W-1:0]               vcnt;
        logic [CNT_W-1:0]               ncnt;
        logic [CNT_W-1:0]               mcnt;
        logic                           fb_seen;
        logic [LOCK_W-1:0]              lock_cnt;
        logic                           locked;
        logic [NUM_POST-1:0][DIV_W-1:0] pcnt;
        logic [NUM_POST-1:0]            pout;
        logic [31:0]                    rdata;
        logic                           err;
    } state_t;

    localparam state_t ST_RST = '{
        ctrl: CTRL_RST, pre_m1: PRE_RST, fb_m1: FB_RST, post: {NUM_POST{POST_RST}},
        sw_state: SW_RUN, ctl: NOMINAL_PERIOD, sync_wait: 1'b1, default: '0};

    state_t           st_reg;
    state_t           st_next;
    logic             p_rise, p_fall, b_rise, b_fall;
    logic             ref_now, ref_rise, tick, ref_ev, fb_ev;
    logic             cur_lost, new_lost, old_fall, new_fall, sw_rise, auto_trig;
    logic             setup, wr, post_hit, post_bad;
    logic [2:0]       post_idx;
    logic [7:0]       post_off;
    post_cfg_t        wcfg;
    logic [DIV_W-1:0] whi, wlo;
    logic [DIV_W-1:0] div;
    logic [NUM_POST-1:0] ce;
    logic [NUM_POST-1:0] prise;

    always_comb begin
        st_next  = st_reg;
        tick     = 1'b0;
        ref_ev   = 1'b0;
        fb_ev    = 1'b0;
        div      = '0;
        ce       = '0;
        prise    = '0;

        p_rise = primary_ref_clock & ~st_reg.p_prev;
        p_fall = ~primary_ref_clock & st_reg.p_prev;
        b_rise = backup_ref_clock & ~st_reg.b_prev;
        b_fall = ~backup_ref_clock & st_reg.b_prev;
        st_next.p_prev = primary_ref_clock;
        st_next.b_prev = backup_ref_clock;

        // [R26] Clock sense by other-edge count
        // [R20] Primary silent for two backup periods
        if (p_rise) begin
            st_next.loss_cnt0 = '0;
            st_next.loss0     = 1'b0;
        end else if (b_rise && !st_reg.loss0) begin
            st_next.loss_cnt0 = st_reg.loss_cnt0 + 1'b1;
            st_next.loss0     = (st_next.loss_cnt0 == LOSS_EDGES);
        end
        if (b_rise) begin
            st_next.loss_cnt1 = '0;
            st_next.loss1     = 1'b0;
        end else if (p_rise && !st_reg.loss1) begin
            st_next.loss_cnt1 = st_reg.loss_cnt1 + 1'b1;
            st_next.loss1     = (st_next.loss_cnt1 == LOSS_EDGES);
        end

        cur_lost  = st_reg.sel ? st_reg.loss1 : st_reg.loss0;
        new_lost  = st_reg.sel ? st_reg.loss0 : st_reg.loss1;
        old_fall  = st_reg.sel ? b_fall : p_fall;
        new_fall  = st_reg.sel ? p_fall : b_fall;
        // [R23] Manual request edge only
        sw_rise   = st_reg.ctrl.sw_req & ~st_reg.req_prev;
        st_next.req_prev = st_reg.ctrl.sw_req;
        // [R16] Automatic trigger, [R18] repeatable
        auto_trig = st_reg.ctrl.auto_en & cur_lost & ~new_lost;

        // [R24] Gate on old fall, swap on new fall
        // [R21] A dead old clock has no fall, so gating happens at once
        case (st_reg.sw_state)
            SW_RUN: begin
                if (sw_rise || auto_trig) begin
                    if (old_fall || cur_lost) begin
                        st_next.gated    = 1'b1;
                        st_next.sw_state = SW_WAIT;
                    end else begin
                        st_next.sw_state = SW_GATE;
                    end
                end
            end
            SW_GATE: begin
                if (old_fall || cur_lost) begin
                    st_next.gated    = 1'b1;
                    st_next.sw_state = SW_WAIT;
                end
            end
            SW_WAIT: begin
                // [R25] Wait for a live target
                if (new_fall && !new_lost) begin
                    st_next.sel      = ~st_reg.sel;
                    st_next.gated    = 1'b0;
                    st_next.sw_state = SW_RUN;
                end
            end
            default: st_next.sw_state = SW_RUN;
        endcase

        ref_now = ~st_reg.gated & (st_reg.sel ? backup_ref_clock : primary_ref_clock);
        st_next.ref_out = ref_now;
        ref_rise = ref_now & ~st_reg.ref_out;

        if (st_reg.ctrl.loop_rst) begin
            // [R11] Loop reset clears and restores nominal
            st_next.ncnt      = '0;
            st_next.mcnt      = '0;
            st_next.vcnt      = '0;
            st_next.ctl       = NOMINAL_PERIOD;
            st_next.locked    = 1'b0;
            st_next.lock_cnt  = '0;
            st_next.fb_seen   = 1'b0;
            st_next.pcnt      = '0;
            st_next.pout      = '0;
            st_next.sync_wait = 1'b1;
        end else if (st_reg.sync_wait) begin
            // [R12] Restart on first selected reference edge
            if (ref_rise) begin
                st_next.sync_wait = 1'b0;
            end
        end else begin
            // A shortened period must not leave the count stranded past its end
            tick = (st_reg.vcnt >= st_reg.ctl - 1'b1);
            st_next.vcnt = tick ? '0 : st_reg.vcnt + 1'b1;
            // [R1] Pre-scale divide 1..512, [R2] no duty counts
            if (ref_rise) begin
                ref_ev = (st_reg.ncnt == st_reg.pre_m1);
                st_next.ncnt = ref_ev ? '0 : st_reg.ncnt + 1'b1;
            end
            // [R1] Feedback divide 1..512
            if (tick) begin
                fb_ev = (st_reg.mcnt == st_reg.fb_m1);
                st_next.mcnt = fb_ev ? '0 : st_reg.mcnt + 1'b1;
            end
            // [R10] Gate low holds control value
            // [R6] Trim drives feedback rate to reference over pre-scale
            if (st_reg.ctrl.det_gate) begin
                if (ref_ev && fb_ev && !st_reg.fb_seen) begin
                    // [R15] Lone coincident feedback builds lock; a second one is a harmonic
                    st_next.fb_seen = 1'b0;
                    if (st_reg.lock_cnt != LOCK_COUNT) begin
                        st_next.lock_cnt = st_reg.lock_cnt + 1'b1;
                    end
                    st_next.locked = (st_next.lock_cnt == LOCK_COUNT);
                end else if (ref_ev || (fb_ev && st_reg.fb_seen)) begin
                    // Feedback early means the oscillator runs fast
                    if (st_reg.fb_seen || fb_ev) begin
                        if (st_reg.ctl != MAX_PERIOD) begin
                            st_next.ctl = st_reg.ctl + 1'b1;
                        end
                    end else if (st_reg.ctl > PER_W'(1)) begin
                        st_next.ctl = st_reg.ctl - 1'b1;
                    end
                    // Realign oscillator phase to the reference edge
                    if (ref_ev) begin
                        st_next.vcnt = '0;
                        st_next.mcnt = '0;
                    end
                    st_next.fb_seen  = fb_ev && !ref_ev;
                    st_next.lock_cnt = '0;
                    st_next.locked   = 1'b0;
                end else if (fb_ev) begin
                    st_next.fb_seen = 1'b1;
                end
            end
            // [R3] Five post counters on the oscillator tick
            for (int i = 0; i < NUM_POST; i++) begin
                // [R7] Chained counter clocks on previous output rise
                // [R8] Chaining fixed by parameter
                ce[i] = (i > 0 && CASCADE_MASK[i]) ? prise[(i + NUM_POST - 1) % NUM_POST] : tick;
                // [R5] Divide is high plus low
                div = DIV_W'(st_reg.post[i].high_m1) + DIV_W'(st_reg.post[i].low_m1) + HL_OFFSET;
                if (st_reg.post[i].bypass) begin
                    st_next.pout[i] = ce[i];
                end else if (ce[i]) begin
                    st_next.pcnt[i] = (st_reg.pcnt[i] == div - 1'b1) ? '0 : st_reg.pcnt[i] + 1'b1;
                    // [R9] High time in whole oscillator cycles
                    st_next.pout[i] = st_next.pcnt[i] <= DIV_W'(st_reg.post[i].high_m1);
                end
                prise[i] = st_next.pout[i] & ~st_reg.pout[i];
            end
        end

        // APB: decode in setup, answer in a single access cycle
        setup    = psel & ~penable;
        wr       = psel & penable & pwrite & ~st_reg.err;
        post_off = paddr - OFF_POST0;
        post_idx = post_off[4:2];
        post_hit = (paddr >= OFF_POST0) && (paddr <= OFF_POST4) && (paddr[1:0] == WORD_ALIGN);
        wcfg     = pwdata[16:0];
        whi      = DIV_W'(wcfg.high_m1);
        wlo      = DIV_W'(wcfg.low_m1);
        // [R4] Uneven duty limited to 256
        post_bad = post_hit && pwrite && !wcfg.bypass && (whi != wlo) &&
                   (whi != wlo + 1'b1) && (wlo != whi + 1'b1) && (whi + wlo + HL_OFFSET > DUTY_ANY_MAX);
        if (setup) begin
            st_next.err   = 1'b0;
            st_next.rdata = '0;
            if (post_hit) begin
                st_next.rdata = 32'(st_reg.post[post_idx]);
                st_next.err   = post_bad;
            end else begin
                case (paddr)
                    OFF_CTRL:    st_next.rdata = 32'(st_reg.ctrl);
                    OFF_PRE:     st_next.rdata = 32'(st_reg.pre_m1);
                    OFF_FB:      st_next.rdata = 32'(st_reg.fb_m1);
                    OFF_STATUS:  st_next.rdata = 32'(status);
                    OFF_CASCADE: st_next.rdata = 32'(CASCADE_MASK);
                    default:     st_next.err   = 1'b1;
                endcase
            end
        end
        if (wr) begin
            if (post_hit) begin
                st_next.post[post_idx] = wcfg;
            end else begin
                case (paddr)
                    OFF_CTRL: st_next.ctrl   = pwdata[3:0];
                    // [R1] A new setting restarts its count, so none is left beyond it
                    OFF_PRE: begin
                        st_next.pre_m1 = pwdata[CNT_W-1:0];
                        st_next.ncnt   = '0;
                    end
                    OFF_FB: begin
                        st_next.fb_m1 = pwdata[CNT_W-1:0];
                        st_next.mcnt  = '0;
                    end
                    default:  st_next.ctrl   = st_next.ctrl;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pready  = 1'b1;
    assign prdata  = st_reg.rdata;
    assign pslverr = st_reg.err;
    assign selected_ref_clock = st_reg.ref_out;
    assign output_clocks      = st_reg.pout;
    // [R17] Loss flags and select indicator among five status bits, [R22] sel high means backup
    assign status = '{busy: st_reg.sw_state != SW_RUN, active_sel: st_reg.sel,
                      backup_loss: st_reg.loss1, primary_loss: st_reg.loss0,
                      locked: st_reg.locked};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_enter_wait;
        st_reg.sw_state == SW_GATE ##1 st_reg.sw_state == SW_WAIT;
    endsequence
    sequence s_sel_swap;
        st_reg.sw_state == SW_WAIT ##1 $changed(st_reg.sel);
    endsequence

    a_reset_clears_loop: assert property (st_reg.ctrl.loop_rst |=> // [R11]
        st_reg.pout == '0 && !st_reg.locked && st_reg.ctl == NOMINAL_PERIOD)
        else $error("loop reset did not clear loop state");
    a_gate_holds_ctl: assert property (!st_reg.ctrl.det_gate && !st_reg.ctrl.loop_rst // [R10]
        && !st_reg.sync_wait |=> $stable(st_reg.ctl))
        else $error("control value moved with detector gated");
    a_loss_raise: assert property (b_rise && !p_rise && !st_reg.loss0 && // [R26]
        st_reg.loss_cnt0 == LOSS_EDGES - 1'b1 |=> status.primary_loss)
        else $error("primary loss flag not raised");
    a_loss_clear: assert property (p_rise |=> !status.primary_loss) // [R26]
        else $error("primary loss flag not cleared by toggling");
    a_gated_wait: assert property (s_enter_wait |-> st_reg.gated && // [R24]
        selected_ref_clock == 1'b0)
        else $error("reference not gated off while waiting");
    a_sel_on_fall: assert property ($changed(st_reg.sel) |-> // [R24]
        $past(st_reg.sw_state) == SW_WAIT && $past(new_fall))
        else $error("select changed outside a new-clock falling edge");
    a_swap_regates: assert property (s_sel_swap |-> !st_reg.gated && // [R22]
        status.active_sel == st_reg.sel)
        else $error("switch did not complete cleanly");
    a_wait_absent: assert property (st_reg.sw_state == SW_WAIT && new_lost |=> // [R25]
        $stable(st_reg.sel))
        else $error("switched to an absent reference");
    a_auto_start: assert property (st_reg.sw_state == SW_RUN && auto_trig |=> // [R16]
        st_reg.sw_state != SW_RUN)
        else $error("automatic switchover did not start");
    a_no_fall_switch: assert property (st_reg.sw_state == SW_RUN && !sw_rise && // [R23]
        !auto_trig |=> st_reg.sw_state == SW_RUN)
        else $error("switch started without a request edge");
    a_pre_range: assert property (st_reg.ncnt <= st_reg.pre_m1 || $changed(st_reg.pre_m1)) // [R1]
        else $error("pre-scale count beyond setting");
    a_duty_reject: assert property (psel && penable && st_reg.err |=> // [R4]
        $stable(st_reg.post) && $stable(st_reg.ctrl))
        else $error("refused write changed a register");

endmodule : clk_synth

// ===== clk_synth_pkg.sv
// Constants and types shared by the clock synthesis loop control block.
// Assumes a 32-bit APB bus with byte addresses and one aligned word per register.
package clk_synth_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_PRE     = 8'h04;
    localparam logic [7:0] OFF_FB      = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0c;
    localparam logic [7:0] OFF_POST0   = 8'h10;
    localparam logic [7:0] OFF_POST4   = 8'h20;
    localparam logic [7:0] OFF_CASCADE = 8'h24;
    localparam int         POST_STRIDE_SHIFT = 2;
    localparam logic [1:0] WORD_ALIGN  = 2'h0;

    // Widths
    localparam int NUM_POST = 5;
    localparam int CNT_W    = 9;   // Stored as value minus one: 1..512
    localparam int HL_W     = 8;   // High/low counts stored minus one: 1..256
    localparam int DIV_W    = 10;
    localparam int PER_W    = 16;
    localparam int LOSS_W   = 3;
    localparam int LOCK_W   = 4;

    // Largest divide allowed when high and low differ by more than one
    localparam logic [DIV_W-1:0] DUTY_ANY_MAX = 10'h100;
    localparam logic [DIV_W-1:0] HL_OFFSET    = 10'h002;

    typedef struct packed {
        logic sw_req;     // Manual switch request, acts on its rising edge
        logic auto_en;    // Automatic switchover enable
        logic det_gate;   // Phase detector output gate
        logic loop_rst;   // Loop reset
    } ctrl_t;

    typedef struct packed {
        logic            bypass;  // Divide by one
        logic [HL_W-1:0] high_m1;
        logic [HL_W-1:0] low_m1;
    } post_cfg_t;

    typedef struct packed {
        logic busy;
        logic active_sel;
        logic backup_loss;
        logic primary_loss;
        logic locked;
    } status_t;

    typedef enum logic [1:0] {
        SW_RUN  = 2'b00,
        SW_GATE = 2'b01,
        SW_WAIT = 2'b10
    } sw_state_t;

    localparam ctrl_t          CTRL_RST = 4'h6;
    localparam logic [CNT_W-1:0] PRE_RST  = 9'h000;
    localparam logic [CNT_W-1:0] FB_RST   = 9'h000;
    localparam post_cfg_t      POST_RST = 17'h00000;

endpackage : clk_synth_pkg

// ===== ref_clock_model.sv
// Two free-running reference clock sources on the far side of the loop.
// Assumes the bench stops a source by lowering its run input.
`timescale 1ns/10ps
module ref_clock_model #(
    parameter int PRI_HALF_NS = 80,
    parameter int BAK_HALF_NS = 90,
    parameter int BAK_SKEW_NS = 5
) (
    input  wire logic run_primary,
    input  wire logic run_backup,
    output logic      primary_ref_clock,
    output logic      backup_ref_clock
);
    // Stable from time zero, rates within 20%
    // A stopped source parks low, as a dead oscillator would
    // Skew keeps backup edges off pclk edges, so sampling never races
    initial begin
        primary_ref_clock = 1'b0;
        backup_ref_clock  = 1'b0;
        #(BAK_SKEW_NS);
        forever #(BAK_HALF_NS) backup_ref_clock = run_backup ? ~backup_ref_clock : 1'b0;
    end
    always #(PRI_HALF_NS) primary_ref_clock = run_primary ? ~primary_ref_clock : 1'b0;
endmodule : ref_clock_model

// ===== tb.sv
// Self-checking bench for the clock loop control block.
// Assumes zero-wait APB and reference clocks far slower than pclk.
`timescale 1ns/10ps
module tb;
    import clk_synth_pkg::*;
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                primary_ref_clock;
    logic                backup_ref_clock;
    logic                selected_ref_clock;
    logic [NUM_POST-1:0] output_clocks;
    status_t             status;
    logic                run_primary = 1'b1;
    logic                run_backup = 1'b1;
    int                  num_errors = 0;
    int                  n_checks = 0;
    always #10 pclk = ~pclk;
    clk_synth uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .primary_ref_clock(primary_ref_clock),
        .backup_ref_clock(backup_ref_clock), .selected_ref_clock(selected_ref_clock),
        .output_clocks(output_clocks), .status(status));
    ref_clock_model refs (.run_primary(run_primary), .run_backup(run_backup),
        .primary_ref_clock(primary_ref_clock), .backup_ref_clock(backup_ref_clock));
    task summarize;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            num_errors++;
            summarize();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, {31'h0, ee});
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask : rd
    // Waits for one status bit, bounded; gives up the run on timeout
    task wait_stat(input int i, input logic v);
        int n;
        n = 0;
        while (status[i] !== v && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, status[i]}, {31'h0, v});
        if (n >= 3000) summarize();
    endtask : wait_stat
    task rises(output int c0, output int c1);
        logic [NUM_POST-1:0] p;
        c0 = 0;
        c1 = 0;
        p = output_clocks;
        repeat (400) begin
            @(posedge pclk);
            if (output_clocks[0] && !p[0]) c0++;
            if (output_clocks[1] && !p[1]) c1++;
            p = output_clocks;
        end
    endtask : rises
    initial begin
        int c0, c1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, status.active_sel}, 32'h0);
        rd(OFF_CTRL, 32'h6); rd(OFF_PRE, 32'h0); rd(OFF_FB, 32'h0); rd(OFF_POST0, 32'h0);
        wr(OFF_CASCADE, 32'h1f, 1'b0); rd(OFF_CASCADE, 32'h0);
        wr(8'h28, 32'h1, 1'b1);
        wr(OFF_PRE, 32'h1ff, 1'b0); rd(OFF_PRE, 32'h1ff); wr(OFF_PRE, 32'h0, 1'b0);
        wr(OFF_FB, 32'h1ff, 1'b0); rd(OFF_FB, 32'h1ff); wr(OFF_FB, 32'h0, 1'b0);
        wr(OFF_POST0 + 8'h08, 32'hffff, 1'b0); rd(OFF_POST0 + 8'h08, 32'hffff);
        wr(OFF_POST0 + 8'h08, 32'hff00, 1'b1); rd(OFF_POST0 + 8'h08, 32'hffff);
        wr(OFF_POST0 + 8'h08, 32'hfe00, 1'b0); rd(OFF_POST0 + 8'h08, 32'hfe00);
        wr(OFF_POST0 + 8'h04, 32'h0101, 1'b0);
        wr(OFF_CTRL, 32'h7, 1'b0); wait_stat(0, 1'b0);
        repeat (20) @(posedge pclk);
        chk({27'h0, output_clocks}, 32'h0);
        wr(OFF_CTRL, 32'h6, 1'b0); wait_stat(0, 1'b1);
        rises(c0, c1);
        // Reference period is 8 pclk, pre and feedback 1: output 0 rises every 16, output 1 every 32
        chk({31'h0, c0 >= 24 && c0 <= 26 && c1 >= 12 && c1 <= 13}, 32'h1);
        wr(OFF_CTRL, 32'h0, 1'b0);
        run_primary <= 1'b0;
        rises(c0, c1);
        // Oscillator keeps its last period while the detector is gated
        chk({31'h0, c0 >= 24 && c0 <= 26}, 32'h1);
        chk({31'h0, status.active_sel}, 32'h0);
        run_primary <= 1'b1;
        wait_stat(1, 1'b0);
        wr(OFF_CTRL, 32'h6, 1'b0);
        wr(OFF_CTRL, 32'he, 1'b0); wait_stat(3, 1'b1); wait_stat(4, 1'b0);
        chk({30'h0, status.backup_loss, status.primary_loss}, 32'h0);
        wr(OFF_CTRL, 32'h6, 1'b0);
        repeat (50) @(posedge pclk);
        chk({31'h0, status.active_sel}, 32'h1);
        wr(OFF_CTRL, 32'h7, 1'b0); wr(OFF_CTRL, 32'h6, 1'b0); wait_stat(0, 1'b1);
        run_backup <= 1'b0;
        wait_stat(2, 1'b1); wait_stat(3, 1'b0);
        run_backup <= 1'b1;
        wait_stat(2, 1'b0);
        run_primary <= 1'b0;
        wait_stat(1, 1'b1); wait_stat(3, 1'b1);
        run_primary <= 1'b1;
        wait_stat(1, 1'b0);
        summarize();
    end
endmodule : tb
